/* File: hdl/otfc_tx_framer.sv */
// Transmit framer: strobes, framing, checksum, spreading and O-QPSK shaping.
`timescale 1ns/10ps
module otfc_tx_framer #(
    parameter int TURN_CYC = otfc_pkg::OTFC_TURN_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic channel_clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    output logic byte_ready,
    output logic chip_out,
    output logic chip_i,
    output logic chip_q,
    output logic signed [7:0] dac_i,
    output logic signed [7:0] dac_q,
    output logic tx_active,
    output logic sfd_flag,
    output logic rx_active,
    output logic [11:0] carrier_mhz
);
    import otfc_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        otfc_state_t state;
        logic [6:0] carrier_word;
        logic [11:0] carrier_mhz;
        logic auto_ck;
        logic rx_after_tx;
        logic [3:0] pre_len;
        logic [15:0] rx_mask;
        logic latched_channel_clear;
        logic [14:0] wait_cnt;
        logic [7:0] ramp_cnt;
        logic [6:0] pulse_cnt;
        logic [4:0] chip_idx;
        logic nib;
        logic [7:0] cur_byte;
        logic [3:0] pre_left;
        logic [6:0] bytes_left;
        logic [15:0] crc;
        logic sfd_flag;
        logic chip_out;
        logic chip_i;
        logic chip_q;
        logic signed [7:0] dac_i;
        logic signed [7:0] dac_q;
        logic [31:0] prdata;
    } otfc_regs_t;

    otfc_regs_t st_r;
    otfc_regs_t st_nxt;

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic chip_of(input logic [3:0] sym, input logic [4:0] idx);
        logic [4:0] pos;
        logic c;
        pos = idx - {sym[2:0], 2'b00};
        c = OTFC_BASE_SEQ[5'd31 - pos];
        if (sym[3] && idx[0]) begin
            c = ~c;
        end
        return c;
    endfunction : chip_of

    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        logic fb;
        c = crc;
        for (int b = 0; b < 8; b++) begin
            fb = c[0] ^ d[b];
            c = {1'b0, c[15:1]};
            if (fb) begin
                c = c ^ OTFC_CRC_POLY_REV;
            end
        end
        return c;
    endfunction : crc_byte

    function automatic logic [7:0] half_sine(input logic [2:0] ph, input logic [7:0] amp);
        logic [7:0] s;
        logic [15:0] p;
        case (ph)
            3'd0, 3'd7: s = 8'h19;
            3'd1, 3'd6: s = 8'h47;
            3'd2, 3'd5: s = 8'h6A;
            default: s = 8'h7D;
        endcase
        p = s * amp;
        return p[15:8];
    endfunction : half_sine

    function automatic logic is_tx(input otfc_state_t s);
        return (s == OTFC_TX_PRE) || (s == OTFC_TX_SFD) || (s == OTFC_TX_BODY)
            || (s == OTFC_TX_RAMP);
    endfunction : is_tx

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic [3:0] stb;
    logic chip_evt;
    logic byte_end;
    logic fetch;
    logic [6:0] q_ph;
    logic [3:0] sym;
    logic [7:0] amp;
    logic [7:0] mag_i;
    logic [7:0] mag_q;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = (paddr == OTFC_CTRL_OFS) || (paddr == OTFC_STROBE_OFS)
        || (paddr == OTFC_STATUS_OFS) || (paddr == OTFC_RXMASK_OFS)
        || (paddr == OTFC_CHKSUM_OFS);
    assign pready = penable;
    assign pslverr = psel && penable && !mapped;
    assign stb = (wr_acc && paddr == OTFC_STROBE_OFS) ? pwdata[3:0] : 4'h0;

    // Chips land on a 125-cycle pulse grid: two chips per microsecond.
    assign chip_evt = is_tx(st_r.state)
        && (st_r.pulse_cnt == 7'd0 || st_r.pulse_cnt == OTFC_Q_OFFSET);
    assign byte_end = chip_evt && st_r.chip_idx == 5'd31 && st_r.nib;
    // The byte stream is pulled only when its byte is due, so an empty
    // source shows up as an underflow at that exact byte boundary.
    assign fetch = byte_end && ((st_r.state == OTFC_TX_SFD)
        || (st_r.state == OTFC_TX_BODY && st_r.bytes_left != 7'd0
            && !(st_r.auto_ck && st_r.bytes_left <= 7'd2)));
    assign byte_ready = fetch;
    assign sym = st_r.nib ? st_r.cur_byte[7:4] : st_r.cur_byte[3:0];
    assign q_ph = (st_r.pulse_cnt >= OTFC_Q_OFFSET) ? st_r.pulse_cnt - OTFC_Q_OFFSET
        : st_r.pulse_cnt + 7'd63;
    assign amp = (st_r.state == OTFC_TX_RAMP) ? st_r.ramp_cnt : 8'hFF;
    assign mag_i = half_sine(st_r.pulse_cnt[6:4], amp);
    assign mag_q = half_sine(q_ph[6:4], amp);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        // Read data is captured in the setup cycle and shown in access.
        if (setup_ph) begin
            case (paddr)
                OTFC_CTRL_OFS: st_nxt.prdata = {16'h0, st_r.pre_len, 2'b00, st_r.rx_after_tx,
                    st_r.auto_ck, 1'b0, st_r.carrier_word};
                OTFC_STATUS_OFS: st_nxt.prdata = {st_r.carrier_mhz, 4'h0, 1'b0,
                    st_r.bytes_left, st_r.sfd_flag, st_r.latched_channel_clear, 3'b000,
                    st_r.state};
                OTFC_RXMASK_OFS: st_nxt.prdata = {16'h0, st_r.rx_mask};
                OTFC_CHKSUM_OFS: st_nxt.prdata = {16'h0, st_r.crc};
                default: st_nxt.prdata = 32'h0;
            endcase
        end
        if (wr_acc && paddr == OTFC_CTRL_OFS) begin
            st_nxt.carrier_word = pwdata[OTFC_CARRIER_LSB +: 7];
            st_nxt.carrier_mhz = OTFC_CARRIER_BASE + {5'h0, pwdata[OTFC_CARRIER_LSB +: 7]};
            st_nxt.auto_ck = pwdata[OTFC_AUTOCK_BIT];
            st_nxt.rx_after_tx = pwdata[OTFC_RXAFTER_BIT];
            st_nxt.pre_len = pwdata[OTFC_PRELEN_LSB +: 4];
        end
        if (wr_acc && paddr == OTFC_RXMASK_OFS) begin
            st_nxt.rx_mask = pwdata[15:0];
        end

        // Modulator: pulse grid, chip emission and symbol/byte stepping.
        if (is_tx(st_r.state)) begin
            st_nxt.pulse_cnt = (st_r.pulse_cnt == OTFC_PULSE_LAST) ? 7'd0
                : st_r.pulse_cnt + 7'd1;
            st_nxt.dac_i = st_r.chip_i ? $signed(mag_i) : -$signed(mag_i);
            st_nxt.dac_q = st_r.chip_q ? $signed(mag_q) : -$signed(mag_q);
        end else begin
            st_nxt.dac_i = 8'sh00;
            st_nxt.dac_q = 8'sh00;
        end
        if (chip_evt && st_r.state != OTFC_TX_RAMP) begin
            st_nxt.chip_out = chip_of(sym, st_r.chip_idx);
            if (st_r.pulse_cnt == 7'd0) begin
                st_nxt.chip_i = chip_of(sym, st_r.chip_idx);
            end else begin
                st_nxt.chip_q = chip_of(sym, st_r.chip_idx);
            end
            st_nxt.chip_idx = st_r.chip_idx + 5'd1;
            if (st_r.chip_idx == 5'd31) begin
                st_nxt.nib = ~st_r.nib;
            end
        end

        // Byte sequencing at the end of every byte.
        if (byte_end) begin
            case (st_r.state)
                OTFC_TX_PRE: begin
                    if (st_r.pre_left == 4'd0) begin
                        st_nxt.cur_byte = OTFC_SFD_BYTE;
                        st_nxt.state = OTFC_TX_SFD;
                    end else begin
                        st_nxt.pre_left = st_r.pre_left - 4'd1;
                        st_nxt.cur_byte = OTFC_PREAMBLE_BYTE;
                    end
                end
                OTFC_TX_SFD: begin
                    st_nxt.sfd_flag = 1'b1;
                    if (byte_valid) begin
                        st_nxt.cur_byte = {1'b0, byte_data[6:0]};
                        st_nxt.bytes_left = byte_data[6:0];
                        st_nxt.state = OTFC_TX_BODY;
                    end else begin
                        st_nxt.ramp_cnt = OTFC_RAMP_CYC;
                        st_nxt.state = OTFC_TX_RAMP;
                    end
                end
                OTFC_TX_BODY: begin
                    st_nxt.bytes_left = st_r.bytes_left - 7'd1;
                    if (st_r.bytes_left == 7'd0) begin
                        st_nxt.bytes_left = 7'd0;
                        st_nxt.ramp_cnt = OTFC_RAMP_CYC;
                        st_nxt.state = OTFC_TX_RAMP;
                    end else if (st_r.auto_ck && st_r.bytes_left == 7'd2) begin
                        st_nxt.cur_byte = st_r.crc[7:0];
                    end else if (st_r.auto_ck && st_r.bytes_left == 7'd1) begin
                        st_nxt.cur_byte = st_r.crc[15:8];
                    end else if (byte_valid) begin
                        st_nxt.cur_byte = byte_data;
                        st_nxt.crc = crc_byte(st_r.crc, byte_data);
                    end else begin
                        st_nxt.ramp_cnt = OTFC_RAMP_CYC;
                        st_nxt.state = OTFC_TX_RAMP;
                    end
                end
                default: begin
                    st_nxt.cur_byte = st_r.cur_byte;
                end
            endcase
        end

        // Turnaround and ramp timers.
        case (st_r.state)
            OTFC_TX_CAL: begin
                st_nxt.wait_cnt = st_r.wait_cnt - 15'd1;
                if (st_r.wait_cnt == 15'd1) begin
                    st_nxt.state = OTFC_TX_PRE;
                    st_nxt.pulse_cnt = 7'd0;
                    st_nxt.chip_idx = 5'd0;
                    st_nxt.nib = 1'b0;
                    st_nxt.crc = 16'h0000;
                    st_nxt.bytes_left = 7'd0;
                    if (st_r.pre_len == 4'd0) begin
                        st_nxt.cur_byte = OTFC_SFD_BYTE;
                        st_nxt.state = OTFC_TX_SFD;
                    end else begin
                        st_nxt.cur_byte = OTFC_PREAMBLE_BYTE;
                        st_nxt.pre_left = st_r.pre_len - 4'd1;
                    end
                end
            end
            OTFC_RX_CAL: begin
                st_nxt.wait_cnt = st_r.wait_cnt - 15'd1;
                if (st_r.wait_cnt == 15'd1) begin
                    st_nxt.state = OTFC_RX;
                end
            end
            OTFC_TX_RAMP: begin
                st_nxt.ramp_cnt = st_r.ramp_cnt - 8'd1;
                if (st_r.ramp_cnt == 8'd1) begin
                    st_nxt.sfd_flag = 1'b0;
                    if (st_r.rx_mask != 16'h0000) begin
                        st_nxt.wait_cnt = 15'(TURN_CYC);
                        st_nxt.state = OTFC_RX_CAL;
                    end else begin
                        st_nxt.state = OTFC_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.wait_cnt = st_r.wait_cnt;
            end
        endcase

        // Strobes win over the running sequence; radio-off is strongest.
        if (stb[OTFC_STB_OFF]) begin
            st_nxt.state = OTFC_IDLE;
            st_nxt.sfd_flag = 1'b0;
        end else if (stb[OTFC_STB_RXON]) begin
            st_nxt.state = OTFC_RX_CAL;
            st_nxt.wait_cnt = 15'(TURN_CYC);
            st_nxt.sfd_flag = 1'b0;
            st_nxt.rx_mask[OTFC_RXMASK_RX_BIT] = 1'b1;
        end else if (stb[OTFC_STB_TXCLR]) begin
            st_nxt.latched_channel_clear = channel_clear;
            if (channel_clear) begin
                st_nxt.state = OTFC_TX_CAL;
                st_nxt.wait_cnt = 15'(TURN_CYC);
                st_nxt.sfd_flag = 1'b0;
            end
        end else if (stb[OTFC_STB_TXON]) begin
            // Restarting from any state also aborts a frame in flight.
            st_nxt.state = OTFC_TX_CAL;
            st_nxt.wait_cnt = 15'(TURN_CYC);
            st_nxt.sfd_flag = 1'b0;
            if (st_r.rx_after_tx) begin
                st_nxt.rx_mask[OTFC_RXMASK_TX_BIT] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
            st_r.state <= OTFC_IDLE;
            st_r.carrier_word <= OTFC_CARRIER_RST;
            st_r.carrier_mhz <= OTFC_CARRIER_BASE + {5'h0, OTFC_CARRIER_RST};
            st_r.auto_ck <= 1'b1;
            st_r.pre_len <= OTFC_PRELEN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign chip_out = st_r.chip_out;
    assign chip_i = st_r.chip_i;
    assign chip_q = st_r.chip_q;
    assign dac_i = st_r.dac_i;
    assign dac_q = st_r.dac_q;
    assign tx_active = is_tx(st_r.state);
    assign sfd_flag = st_r.sfd_flag;
    assign rx_active = (st_r.state == OTFC_RX);
    assign carrier_mhz = st_r.carrier_mhz;
endmodule : otfc_tx_framer

/* File: pkg/otfc_pkg.sv */
// Constants, types and register map of the transmit framer.
package otfc_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] OTFC_CTRL_OFS = 8'h00;
    localparam logic [7:0] OTFC_STROBE_OFS = 8'h04;
    localparam logic [7:0] OTFC_STATUS_OFS = 8'h08;
    localparam logic [7:0] OTFC_RXMASK_OFS = 8'h0C;
    localparam logic [7:0] OTFC_CHKSUM_OFS = 8'h10;
    localparam int OTFC_CARRIER_LSB = 0;
    localparam int OTFC_AUTOCK_BIT = 8;
    localparam int OTFC_RXAFTER_BIT = 9;
    localparam int OTFC_PRELEN_LSB = 12;
    localparam int OTFC_STB_TXON = 0;
    localparam int OTFC_STB_TXCLR = 1;
    localparam int OTFC_STB_RXON = 2;
    localparam int OTFC_STB_OFF = 3;
    localparam int OTFC_RXMASK_TX_BIT = 14;
    localparam int OTFC_RXMASK_RX_BIT = 15;
    localparam logic [6:0] OTFC_CARRIER_RST = 7'h0B;
    localparam logic [3:0] OTFC_PRELEN_RST = 4'h4;
    localparam logic [11:0] OTFC_CARRIER_BASE = 12'h95A;
    // ****************************************************************
    // Frame and modulation
    // ****************************************************************
    localparam logic [7:0] OTFC_PREAMBLE_BYTE = 8'h00;
    localparam logic [7:0] OTFC_SFD_BYTE = 8'hA7;
    localparam logic [31:0] OTFC_BASE_SEQ = 32'hD9C3522E;
    localparam logic [15:0] OTFC_CRC_POLY_REV = 16'h8408;
    localparam logic [6:0] OTFC_PULSE_LAST = 7'h7C;
    localparam logic [6:0] OTFC_Q_OFFSET = 7'h3E;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int OTFC_CLK_MHZ = 125;
    localparam int OTFC_TURN_US = 192;
    localparam int OTFC_RAMP_US = 2;
    localparam int OTFC_TURN_CYC = OTFC_TURN_US * OTFC_CLK_MHZ;
    localparam logic [7:0] OTFC_RAMP_CYC = 8'(OTFC_RAMP_US * OTFC_CLK_MHZ);
    typedef enum logic [2:0] {
        OTFC_IDLE, OTFC_RX_CAL, OTFC_RX, OTFC_TX_CAL,
        OTFC_TX_PRE, OTFC_TX_SFD, OTFC_TX_BODY, OTFC_TX_RAMP
    } otfc_state_t;
endpackage : otfc_pkg

/* File: verification/otfc_chk.sv */
// Concurrent checks on the ports of the transmit framer.
`timescale 1ns/10ps
module otfc_chk #(
    parameter int TURN_CYC = otfc_pkg::OTFC_TURN_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire logic signed [7:0] dac_i,
    input wire logic signed [7:0] dac_q,
    input wire logic tx_active,
    input wire logic sfd_flag,
    input wire logic rx_active,
    input wire logic [11:0] carrier_mhz
);
    import otfc_pkg::*;
    localparam int TURN_LO = TURN_CYC - 2;
    localparam int TURN_HI = TURN_CYC + 3;
    logic stb_wr, ctl_wr, gap_ok_r;
    logic [15:0] turn_r, gap_r;
    assign stb_wr = psel && penable && pwrite && paddr == OTFC_STROBE_OFS;
    assign ctl_wr = psel && penable && pwrite && paddr == OTFC_CTRL_OFS;
    // Counters saturate, so a long idle spell never wraps into a false match.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            turn_r <= 16'h0000;
            gap_r <= 16'h0000;
            gap_ok_r <= 1'b0;
        end else begin
            turn_r <= (stb_wr && pwdata[1:0] != 2'h0) ? 16'h0000 : turn_r + 16'(turn_r != 16'hFFFF);
            gap_r <= byte_ready ? 16'h0000 : gap_r + 16'(gap_r != 16'hFFFF);
            gap_ok_r <= byte_ready || (gap_ok_r && tx_active);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_carrier_sum: assert property (ctl_wr |=>
        carrier_mhz == OTFC_CARRIER_BASE + {5'h00, $past(pwdata[6:0])})
        else $error("carrier does not follow word");
    a_off_idle: assert property (stb_wr && pwdata[OTFC_STB_OFF] |=> !tx_active && !rx_active)
        else $error("radio off did not idle");
    a_rx_abort: assert property (stb_wr && pwdata[OTFC_STB_RXON] |=> !tx_active)
        else $error("receive strobe left transmit running");
    a_tx_turn: assert property ($rose(tx_active) |-> turn_r >= TURN_LO && turn_r <= TURN_HI)
        else $error("preamble start not at turnaround");
    a_byte_pulse: assert property (byte_ready |-> tx_active ##1 !byte_ready)
        else $error("byte request not a single pulse");
    a_byte_gap: assert property (byte_ready && gap_ok_r |-> gap_r >= 16'h0F9D && gap_r <= 16'h0FA2)
        else $error("byte spacing off");
    a_underflow_ramp: assert property (byte_ready && !byte_valid |=>
        tx_active [*8] ##[200:260] !tx_active)
        else $error("underflow ramp length off");
    a_sfd_stretch: assert property ($fell(sfd_flag) |-> $fell(tx_active))
        else $error("delimiter flag not held to ramp end");
    a_dac_quiet: assert property (!tx_active && !$past(tx_active) |-> dac_i == 8'sh00 && dac_q == 8'sh00)
        else $error("dac active outside transmit");
endmodule : otfc_chk
bind otfc_tx_framer otfc_chk #(.TURN_CYC(TURN_CYC)) otfc_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .byte_valid(byte_valid), .byte_ready(byte_ready),
    .dac_i(dac_i), .dac_q(dac_q), .tx_active(tx_active), .sfd_flag(sfd_flag),
    .rx_active(rx_active), .carrier_mhz(carrier_mhz));

/* File: verification/otfc_byte_src.sv */
// Frame byte source standing in for the buffer side of the byte link.
`timescale 1ns/10ps
module otfc_byte_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic byte_ready,
    input wire logic starve,
    input wire logic rewind,
    output logic byte_valid,
    output logic [7:0] byte_data
);
    // Length 5 with the reserved top bit set on purpose, then FCF 0x8841 low byte first.
    localparam logic [7:0] FRAME [6] = '{8'h85, 8'h41, 8'h88, 8'h01, 8'hC1, 8'hC2};
    logic [2:0] idx_r;
    logic [7:0] last_r;
    assign byte_valid = !starve && idx_r < 3'h6;
    // A drained source shows the inverse of its last byte, never a stale copy.
    assign byte_data = byte_valid ? FRAME[idx_r] : ~last_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 3'h0;
            last_r <= 8'h00;
        end else if (rewind) begin
            idx_r <= 3'h0;
        end else if (byte_ready && byte_valid) begin
            idx_r <= idx_r + 3'h1;
            last_r <= FRAME[idx_r];
        end
    end
endmodule : otfc_byte_src

/* File: verification/otfc_tx_framer_test.sv */
// Self-checking bench for the transmit framer.
`timescale 1ns/10ps
module otfc_tx_framer_test;
    import otfc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic channel_clear = 1'b0, starve = 1'b0, rewind = 1'b0;
    logic [7:0] paddr = 8'h00, byte_data;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, byte_valid, byte_ready, chip_out, tx_active, sfd_flag, rx_active;
    logic chip_i, chip_q;
    logic [11:0] carrier_mhz;
    logic [63:0] chips;
    int failures = 0, compares = 0, cyc = 0, pulls = 0, t0, p0, k;
    otfc_tx_framer #(.TURN_CYC(20)) otfc_tx_framer_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .channel_clear(channel_clear),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
        .chip_out(chip_out), .chip_i(chip_i), .chip_q(chip_q), .dac_i(), .dac_q(),
        .tx_active(tx_active), .sfd_flag(sfd_flag), .rx_active(rx_active),
        .carrier_mhz(carrier_mhz));
    otfc_byte_src otfc_byte_src_i (.pclk(pclk), .presetn(presetn), .byte_ready(byte_ready),
        .starve(starve), .rewind(rewind), .byte_valid(byte_valid), .byte_data(byte_data));
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (byte_ready && byte_valid) pulls <= pulls + 1;
    end
    task print_verdict;
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        chk({31'h0, pslverr}, {31'h0, a > OTFC_CHKSUM_OFS});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(q & m, e);
    endtask : rd
    task strobe(input int b);
        xfer(OTFC_STROBE_OFS, 1'b1, 32'h1 << b);
    endtask : strobe
    task go(input int b);
        rewind <= 1'b1;
        @(posedge pclk);
        rewind <= 1'b0;
        strobe(b);
    endtask : go
    function automatic logic pick(input int w);
        case (w)
            0: return sfd_flag;
            1: return tx_active;
            2: return !tx_active;
            3: return rx_active;
            default: return byte_ready;
        endcase
    endfunction : pick
    task wait_for(input int w);
        int n;
        n = 0;
        @(posedge pclk);
        while (pick(w) !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < 40000), 32'h1);
    endtask : wait_for
    // Reflected checksum, zero start, each byte least significant bit first.
    function automatic logic [15:0] fcs(input logic [23:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 0; i < 24; i++) c = (c >> 1) ^ ((c[0] ^ d[i]) ? 16'h8408 : 16'h0000);
        return c;
    endfunction : fcs
    initial begin
        #800000;
        failures++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({20'h0, carrier_mhz}, 32'h965);
        rd(OTFC_CTRL_OFS, 32'hFFFFFFFF, 32'h410B);
        rd(OTFC_STROBE_OFS, 32'hFFFFFFFF, 32'h0);
        rd(8'h14, 32'hFFFFFFFF, 32'h0);
        for (k = 11; k <= 26; k++) begin
            xfer(OTFC_CTRL_OFS, 1'b1, 32'h4100 | 32'(11 + 5 * (k - 11)));
            rd(OTFC_STATUS_OFS, 32'hFFF00000, 32'(2405 + 5 * (k - 11)) << 20);
            chk({20'h0, carrier_mhz}, 32'(2405 + 5 * (k - 11)));
        end
        xfer(OTFC_CTRL_OFS, 1'b1, 32'h417F);
        rd(OTFC_STATUS_OFS, 32'hFFF00000, 32'h9D900000);
        strobe(OTFC_STB_TXCLR);
        rd(OTFC_STATUS_OFS, 32'h47, 32'h0);
        channel_clear <= 1'b1;
        strobe(OTFC_STB_TXCLR);
        rd(OTFC_STATUS_OFS, 32'h47, 32'h43);
        wait_for(1);
        strobe(OTFC_STB_TXON);
        rd(OTFC_STATUS_OFS, 32'h7, 32'h3);
        strobe(OTFC_STB_RXON);
        rd(OTFC_STATUS_OFS, 32'h7, 32'h1);
        strobe(OTFC_STB_OFF);
        rd(OTFC_STATUS_OFS, 32'h7, 32'h0);
        xfer(OTFC_CTRL_OFS, 1'b1, 32'h230F);
        xfer(OTFC_RXMASK_OFS, 1'b1, 32'h0);
        p0 = pulls;
        go(OTFC_STB_TXON);
        rd(OTFC_RXMASK_OFS, 32'hFFFF, 32'h4000);
        rd(OTFC_STATUS_OFS, 32'h40, 32'h40);
        wait_for(1);
        t0 = cyc;
        wait_for(0);
        chk(32'((cyc - t0) inside {[11935:11942]}), 32'h1);
        t0 = cyc;
        // Mid-chip sampling leaves about half a chip (30 cycles) of slack either way.
        for (k = 0; k < 64; k++) begin
            while (cyc - t0 < (k / 2) * 125 + ((k % 2) ? 155 : 93)) @(posedge pclk);
            chips[63 - k] = chip_out;
            chk({31'h0, (k % 2) ? chip_q : chip_i}, {31'h0, chip_out});
        end
        chk(chips[63:32], 32'h3522ED9C);
        chk(chips[31:0], 32'hD9C3522E);
        wait_for(2);
        chk(32'(pulls - p0), 32'h4);
        rd(OTFC_CHKSUM_OFS, 32'hFFFF, {16'h0, fcs(24'h018841)});
        rd(OTFC_STATUS_OFS, 32'h7, 32'h1);
        wait_for(3);
        xfer(OTFC_CTRL_OFS, 1'b1, 32'h200F);
        xfer(OTFC_RXMASK_OFS, 1'b1, 32'h0);
        p0 = pulls;
        go(OTFC_STB_TXON);
        wait_for(1);
        wait_for(2);
        chk(32'(pulls - p0), 32'h6);
        rd(OTFC_STATUS_OFS, 32'h7, 32'h0);
        starve <= 1'b1;
        go(OTFC_STB_TXON);
        wait_for(4);
        t0 = cyc;
        wait_for(2);
        chk(32'((cyc - t0) inside {[247:256]}), 32'h1);
        starve <= 1'b0;
        print_verdict;
    end
endmodule : otfc_tx_framer_test
